// file: rtl/supply_bias_pkg.sv
// Package with the register map, field layout and reset values of the supply and bias controls
package supply_bias_pkg;

	// Bus widths
	localparam int unsigned addr_width = 12;
	localparam int unsigned data_width = 32;
	localparam int unsigned reg_width  = 16;
	localparam int unsigned reg_count  = 7;

	// Register indices; byte address is four times the index
	localparam logic [7:0] regulator1_control_idx            = 8'h3b;
	localparam logic [7:0] regulator2_control_idx            = 8'h3c;
	localparam logic [7:0] bias_supply1_control_idx          = 8'h3d;
	localparam logic [7:0] bias_supply2_control_idx          = 8'h3e;
	localparam logic [7:0] charge_pump_enable_control_idx    = 8'h4c;
	localparam logic [7:0] charge_pump_discharge_control_idx = 8'h4d;
	localparam logic [7:0] envelope_tracking_control_idx     = 8'h51;

	// Slot order used by the register array
	localparam int unsigned slot_reg1    = 0;
	localparam int unsigned slot_reg2    = 1;
	localparam int unsigned slot_bias1   = 2;
	localparam int unsigned slot_bias2   = 3;
	localparam int unsigned slot_charge_pump_enable  = 4;
	localparam int unsigned slot_cp_dis  = 5;
	localparam int unsigned slot_envelope = 6;

	localparam logic [reg_count-1:0][7:0] reg_index = {
		envelope_tracking_control_idx,
		charge_pump_discharge_control_idx,
		charge_pump_enable_control_idx,
		bias_supply2_control_idx,
		bias_supply1_control_idx,
		regulator2_control_idx,
		regulator1_control_idx
	};

	// Field positions
	localparam int unsigned regulator1_vsel_lsb  = 1;
	localparam int unsigned regulator1_disch_bit = 0;
	localparam int unsigned regulator2_vsel_lsb  = 1;
	localparam int unsigned regulator2_disch_bit = 0;
	localparam int unsigned bias_rate_bit        = 5;
	localparam int unsigned bias_mode_bit        = 4;
	localparam int unsigned bias_level_lsb       = 1;
	localparam int unsigned bias_disch_bit       = 0;
	localparam int unsigned cp_enable_bit        = 15;
	localparam int unsigned charge_pump_discharge_sel_bit         = 15;
	localparam int unsigned envelope_src_lsb     = 8;
	localparam int unsigned dynamic_power_bit    = 0;

	// Implemented bits per register
	localparam logic [reg_count-1:0][15:0] reg_mask = {
		16'h0301, 16'h8000, 16'h8000, 16'h003f, 16'h003f, 16'h0007, 16'h000f
	};

	// Values after reset
	localparam logic [reg_count-1:0][15:0] reg_reset = {
		16'h0000, 16'h8000, 16'h0000, 16'h0039, 16'h0039, 16'h0003, 16'h000d
	};

	// AXI response codes
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// file: rtl/masked_reg.sv
// One 16-bit control register with byte strobes and a mask of implemented bits
`timescale 1ns/1ps
module masked_reg #(
	parameter logic [15:0] reset_value = 16'h0000,
	parameter logic [15:0] field_mask  = 16'hffff
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write port
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_strb,
	// Stored value
	output logic      [15:0] q
);

	logic [15:0] next_q;
	logic [15:0] lane_mask;

	always_comb begin
		lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & field_mask;
		next_q    = q;
		if (wr_en) begin
			// Unassigned bits never change and stay zero
			next_q = (q & ~lane_mask) | (wr_data & lane_mask);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= reset_value;
		end else begin
			q <= next_q;
		end
	end

endmodule

// file: rtl/supply_bias_config_regs.sv
// AXI4-Lite register bank for regulator, bias and charge pump controls
//
// Overview of operation
// - Regulator one voltage select, reset 110
// - Regulator one discharge select, reset 1
// - Regulator two voltage select, reset 01
// - Regulator two discharge select, reset 1
// - Bias ramp rate bit five, reset 1
// - Bias bypass select bit four, reset 1
// - Bias level bits 3:1, reset 100
// - Bias discharge bit zero, reset 1
// - Second bias register mirrors first, independently
// - Pump enable resets 0, discharge resets 1
// - Dynamic pump power bit zero, reset 0
// - Envelope source bits 9:8, reset 00
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module supply_bias_config_regs (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	// Regulator controls
	output logic      [2:0]  regulator1_voltage_sel,
	output logic             regulator1_discharge_sel,
	output logic      [1:0]  regulator2_voltage_sel,
	output logic             regulator2_discharge_sel,
	// Bias output one controls
	output logic             bias1_ramp_rate,
	output logic             bias1_bypass_sel,
	output logic      [2:0]  bias1_level,
	output logic             bias1_discharge_sel,
	// Bias output two controls
	output logic             bias2_ramp_rate,
	output logic             bias2_bypass_sel,
	output logic      [2:0]  bias2_level,
	output logic             bias2_discharge_sel,
	// Charge pump controls
	output logic             charge_pump_enable,
	output logic             charge_pump_discharge_sel,
	output logic      [1:0]  envelope_source_sel,
	output logic             dynamic_pump_power
);

	// Write channel state
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [15:0] w_data;
	logic [1:0]  w_strb;
	logic        next_aw_held;
	logic        next_w_held;
	logic [11:0] next_aw_addr;
	logic [15:0] next_w_data;
	logic [1:0]  next_w_strb;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;

	// Read channel state
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	// Register array
	logic [supply_bias_pkg::reg_count-1:0][15:0] reg_q;
	logic [supply_bias_pkg::reg_count-1:0]       wr_hit;
	logic [supply_bias_pkg::reg_count-1:0]       rd_hit;
	logic                                        wr_fire;
	logic [15:0]                                 rd_value;

	// Index decode; low two address bits are ignored
	logic [9:0] wr_index;
	logic [9:0] rd_index;

	assign wr_index = aw_addr[11:2];
	assign rd_index = s_axi_araddr[11:2];
	// A parked write waits while the previous response is still unanswered,
	// so a slow master never loses a response
	assign wr_fire  = aw_held && w_held && !s_axi_bvalid;

	// Every field is stored at its documented reset value and mask
	genvar gi;
	generate
		for (gi = 0; gi < supply_bias_pkg::reg_count; gi++) begin : g_reg
			assign wr_hit[gi] = (wr_index == {2'h0, supply_bias_pkg::reg_index[gi]});
			assign rd_hit[gi] = (rd_index == {2'h0, supply_bias_pkg::reg_index[gi]});
			masked_reg #(
				.reset_value (supply_bias_pkg::reg_reset[gi]),
				.field_mask  (supply_bias_pkg::reg_mask[gi])
			) u_reg (
				.aclk    (aclk),
				.aresetn (aresetn),
				.wr_en   (wr_fire && wr_hit[gi]),
				.wr_data (w_data),
				.wr_strb (w_strb),
				.q       (reg_q[gi])
			);
		end
	endgenerate

	// Write channels: address and data are taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata[15:0];
			next_w_strb = s_axi_wstrb[1:0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			// Unmapped addresses answer with an error and store nothing
			next_bresp   = (|wr_hit) ? supply_bias_pkg::resp_okay
			                         : supply_bias_pkg::resp_slverr;
		end
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 16'h0000;
			w_strb        <= 2'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
		end
	end

	// Read mux; unassigned bits and unmapped addresses read zero
	always_comb begin
		rd_value = 16'h0000;
		for (int i = 0; i < supply_bias_pkg::reg_count; i++) begin
			if (rd_hit[i]) begin
				rd_value = reg_q[i];
			end
		end
	end

	// Read channel: one outstanding read, answered the cycle after acceptance
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata  = {16'h0000, rd_value};
			next_rresp  = (|rd_hit) ? supply_bias_pkg::resp_okay
			                        : supply_bias_pkg::resp_slverr;
		end
		// Address is refused while a response stands, so one read at most is open
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// Field outputs come straight from the register flops
	localparam int unsigned s1 = supply_bias_pkg::slot_reg1;
	localparam int unsigned s2 = supply_bias_pkg::slot_reg2;
	localparam int unsigned ce = supply_bias_pkg::slot_charge_pump_enable;
	localparam int unsigned cd = supply_bias_pkg::slot_cp_dis;
	localparam int unsigned ev = supply_bias_pkg::slot_envelope;

	// Codes map to 2.4 V to 3.1 V in 100 mV steps in the analogue block
	assign regulator1_voltage_sel =
		reg_q[s1][supply_bias_pkg::regulator1_vsel_lsb +: 3];
	// Clearing is software's duty while jack sensing uses mode 01
	assign regulator1_discharge_sel =
		reg_q[s1][supply_bias_pkg::regulator1_disch_bit];
	// Code 00 is stored even though it has no defined voltage
	assign regulator2_voltage_sel =
		reg_q[s2][supply_bias_pkg::regulator2_vsel_lsb +: 2];
	assign regulator2_discharge_sel =
		reg_q[s2][supply_bias_pkg::regulator2_disch_bit];

	// Both bias outputs share one field layout, so one loop serves them;
	// channel 0 is bias output one, channel 1 bias output two
	logic [1:0]      bias_ramp;
	logic [1:0]      bias_bypass;
	logic [1:0][2:0] bias_lvl;
	logic [1:0]      bias_disch;

	genvar gb;
	generate
		for (gb = 0; gb < 2; gb++) begin : g_bias
			localparam int unsigned slot = supply_bias_pkg::slot_bias1 + gb;
			// High selects the pop-free ramp, low the fast one
			assign bias_ramp[gb]   =
				reg_q[slot][supply_bias_pkg::bias_rate_bit];
			// High selects bypass, low the regulated level
			assign bias_bypass[gb] =
				reg_q[slot][supply_bias_pkg::bias_mode_bit];
			// Level only matters while bypass is off
			assign bias_lvl[gb]    =
				reg_q[slot][supply_bias_pkg::bias_level_lsb +: 3];
			// High discharges the output while it is disabled
			assign bias_disch[gb]  =
				reg_q[slot][supply_bias_pkg::bias_disch_bit];
		end
	endgenerate

	// Bias output one
	assign bias1_ramp_rate     = bias_ramp[0];
	assign bias1_bypass_sel    = bias_bypass[0];
	assign bias1_level         = bias_lvl[0];
	assign bias1_discharge_sel = bias_disch[0];

	// Bias output two, stored and driven independently of output one
	assign bias2_ramp_rate     = bias_ramp[1];
	assign bias2_bypass_sel    = bias_bypass[1];
	assign bias2_level         = bias_lvl[1];
	assign bias2_discharge_sel = bias_disch[1];

	// Pump enable resets low; its discharge select sits in the next register

	assign charge_pump_enable        = reg_q[ce][supply_bias_pkg::cp_enable_bit];
	assign charge_pump_discharge_sel = reg_q[cd][supply_bias_pkg::charge_pump_discharge_sel_bit];
	// Reserved codes 01 and 11 are stored as written
	assign envelope_source_sel =
		reg_q[ev][supply_bias_pkg::envelope_src_lsb +: 2];
	assign dynamic_pump_power  = reg_q[ev][supply_bias_pkg::dynamic_power_bit];

endmodule

// file: test/supply_bias_config_regs_assertions.sv
// Bus protocol and field checks for the supply and bias register bank
`timescale 1ns/1ps
module supply_bias_checker (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Write channels
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [1:0]  s_axi_bresp,
	// Read channels
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [11:0] s_axi_araddr,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	// Regulator one fields
	input logic [2:0]  regulator1_voltage_sel,
	input logic        regulator1_discharge_sel
);
	logic ar_take;
	logic mapped;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign mapped = s_axi_araddr[11:2] inside {10'h03b, 10'h03c, 10'h03d, 10'h03e,
		10'h04c, 10'h04d, 10'h051};
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address accepted twice");
	chk_resp_after_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	chk_r_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read data late");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_r_unmapped: assert property (ar_take && !mapped |=> s_axi_rresp == 2'h2
		&& s_axi_rdata == 32'h0) else $error("unmapped read answered wrongly");
	chk_reg1_stable: assert property (!$rose(s_axi_bvalid) |->
		$stable({regulator1_voltage_sel, regulator1_discharge_sel}))
		else $error("regulator one changed without a write");
	chk_reg1_read: assert property (ar_take && s_axi_araddr[11:2] == 10'h03b |=>
		$rose(s_axi_bvalid) || s_axi_rdata[3:0] == {regulator1_voltage_sel,
		regulator1_discharge_sel}) else $error("regulator one readback differs");
endmodule

bind supply_bias_config_regs supply_bias_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .regulator1_voltage_sel(regulator1_voltage_sel),
	.regulator1_discharge_sel(regulator1_discharge_sel));

// file: test/supply_bias_config_regs_tb_top.sv
// Self-checking bench for the supply and bias register bank
`timescale 1ns/1ps
module supply_bias_config_regs_tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        bry = 1'b0;
	logic        arv = 1'b0;
	logic        rry = 1'b0;
	logic [11:0] awa = 12'h000;
	logic [11:0] ara = 12'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0]  ws = 4'h0;
	logic        awr, wr_rdy, bv, arr, rv;
	logic [1:0]  br, rr;
	logic [31:0] rd;
	logic [23:0] fo;
	logic [2:0]  c;
	int          fail_count = 0;
	int          n_checks = 0;
	int          n_wait;
	logic [11:0] ad[7] = '{12'h0ec, 12'h0f0, 12'h0f4, 12'h0f8, 12'h130, 12'h134, 12'h144};
	logic [15:0] rst[7] = '{16'h000d, 16'h0003, 16'h0039, 16'h0039, 16'h0000, 16'h8000, 16'h0000};
	logic [15:0] mk[7] = '{16'h000f, 16'h0007, 16'h003f, 16'h003f, 16'h8000, 16'h8000, 16'h0301};

	always #5 aclk = ~aclk;

	supply_bias_config_regs DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.regulator1_voltage_sel(fo[23:21]), .regulator1_discharge_sel(fo[20]),
		.regulator2_voltage_sel(fo[19:18]), .regulator2_discharge_sel(fo[17]),
		.bias1_ramp_rate(fo[16]), .bias1_bypass_sel(fo[15]), .bias1_level(fo[14:12]),
		.bias1_discharge_sel(fo[11]), .bias2_ramp_rate(fo[10]), .bias2_bypass_sel(fo[9]),
		.bias2_level(fo[8:6]), .bias2_discharge_sel(fo[5]), .charge_pump_enable(fo[4]),
		.charge_pump_discharge_sel(fo[3]), .envelope_source_sel(fo[2:1]),
		.dynamic_pump_power(fo[0]));

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	// One clock edge of a bounded wait
	task automatic tick();
		@(posedge aclk);
		n_wait++;
		if (n_wait > 100) begin
			chk("handshake wait", 32'h0, 32'h1);
			end_sim();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		logic ad_done, wd_done;
		ad_done = 1'b0;
		wd_done = 1'b0;
		n_wait = 0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(ad_done && wd_done)) begin
			tick();
			if (awv && awr) begin
				ad_done = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr_rdy) begin
				wd_done = 1'b1;
				wv <= 1'b0;
			end
		end
		do tick(); while (!bv);
		chk("bresp", {30'h0, br}, {30'h0, e});
		bry <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		n_wait = 0;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do tick(); while (!arr);
		arv <= 1'b0;
		do tick(); while (!rv);
		chk("rdata", rd, e);
		chk("rresp", {30'h0, rr}, {30'h0, er});
		rry <= 1'b0;
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		chk("fields", {8'h0, fo}, 32'hd7cf28);
		for (int i = 0; i < 7; i++) begin
			rdc(ad[i], {16'h0, rst[i]}, 2'h0);
		end
		for (int i = 0; i < 7; i++) begin
			wr(ad[i], 32'hffffffff, 4'hf, 2'h0);
			rdc(ad[i], {16'h0, mk[i]}, 2'h0);
		end
		chk("fields", {8'h0, fo}, 32'hffffff);
		// Only the low lane is written, so the discharge bit keeps its value
		wr(12'h134, 32'h0, 4'h1, 2'h0);
		rdc(12'h134, 32'h8000, 2'h0);
		wr(12'h0f8, 32'h0, 4'h3, 2'h0);
		chk("fields", {8'h0, fo}, 32'hfff81f);
		for (c = 3'h0; c < 3'h4; c++) begin
			wr(12'h144, {22'h0, c[1:0], 7'h0, c[0]}, 4'h3, 2'h0);
			chk("envelope", {29'h0, fo[2:0]}, {29'h0, c[1:0], c[0]});
		end
		wr(12'h0f0, 32'h0, 4'hf, 2'h0);
		rdc(12'h0f0, 32'h0, 2'h0);
		wr(12'h100, 32'hffffffff, 4'hf, 2'h2);
		rdc(12'h100, 32'h0, 2'h2);
		// Software clears regulator one discharge before using jack sense mode 01
		wr(12'h0ec, 32'h0000000c, 4'h1, 2'h0);
		chk("reg1 discharge", {31'h0, fo[20]}, 32'h0);
		chk("reg1 voltage", {29'h0, fo[23:21]}, 32'h6);
		rdc(12'h0ec, 32'h000c, 2'h0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk("fields", {8'h0, fo}, 32'hd7cf28);
		rdc(12'h0ec, 32'h000d, 2'h0);
		end_sim();
	end
endmodule
